/* rtl/ptp_cfg_pkg.sv */
// Constants, types and helpers for the page-six clock-output and status-frame configuration bank
package ptp_cfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_PAGE_SELECT = 5'h13;
  localparam logic [4:0] ADDR_CLOCK_OUTPUT_CONTROL = 5'h14;
  localparam logic [4:0] ADDR_STATUS_FRAME_HEADER_CFG = 5'h15;
  localparam logic [4:0] ADDR_STATUS_FRAME_SRC_IP_HIGH = 5'h16;
  localparam logic [4:0] ADDR_STATUS_FRAME_SRC_IP_LOW = 5'h17;

  // ----------------------------------------------------------------
  // Page selection
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_PAGE = 3'h6;
  localparam logic [2:0] PAGE_SELECT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Clock-output control fields
  // ----------------------------------------------------------------
  localparam int CLKOUT_ENABLE_BIT = 15;
  localparam int CLKOUT_ROOT_SELECT_BIT = 14;
  localparam int CLKOUT_EDGE_RATE_BIT = 13;
  localparam int CLKOUT_DIVISOR_MSB = 7;
  localparam logic [4:0] CLKOUT_RESERVED_VALUE = 5'h00;
  localparam logic CLKOUT_ENABLE_RST = 1'b1;
  localparam logic CLKOUT_ROOT_SELECT_RST = 1'b0;
  localparam logic CLKOUT_EDGE_RATE_RST = 1'b0;
  localparam logic [7:0] CLKOUT_DIVISOR_RST = 8'h0a;
  localparam logic [7:0] CLKOUT_DIVISOR_MIN = 8'h02;
  localparam logic ROOT_PHASE_GENERATION_MODULE = 1'b1;
  localparam logic ROOT_FREQUENCY_CONTROLLED_OSCILLATOR = 1'b0;
  localparam int ROOT_CLOCK_MHZ = 250;

  // ----------------------------------------------------------------
  // Status-frame header and source address fields
  // ----------------------------------------------------------------
  localparam int HEADER_MSG_KIND_LSB = 0;
  localparam int HEADER_TRANSPORT_LSB = 4;
  localparam int HEADER_VERSION_LSB = 8;
  localparam int HEADER_RESERVED_NIBBLE_LSB = 12;
  localparam logic [15:0] HEADER_CFG_RST = 16'h0000;
  localparam logic [15:0] SRC_IP_RST = 16'h0000;
  localparam logic [1:0] HEADER_BYTES = 2'h2;
  localparam logic [1:0] SRC_IP_BYTES_M1 = 2'h3;

  typedef enum logic [2:0] {
    FRM_IDLE = 3'b001,
    FRM_HDR = 3'b010,
    FRM_IP = 3'b100
  } frame_state_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic upper);
    pick_byte = upper ? word[15:8] : word[7:0];
  endfunction : pick_byte

  function automatic logic [7:0] high_phase_len(input logic [7:0] div);
    logic [8:0] sum;
    sum = {1'b0, div} + 9'h001;
    high_phase_len = sum[8:1];
  endfunction : high_phase_len

endpackage : ptp_cfg_pkg

/* rtl/ptp_cfg_if.sv */
// Configuration carrier between decode, register store and clock divider
`timescale 1ns/1ps
interface ptp_cfg_if;
  logic wr_coc;
  logic wr_hdr;
  logic wr_ip_hi;
  logic wr_ip_lo;
  logic [15:0] wdata;
  logic clkout_enable;
  logic clkout_root_select;
  logic clkout_edge_rate;
  logic [7:0] clkout_divisor;
  logic [15:0] header_word;
  logic [15:0] src_ip_high;
  logic [15:0] src_ip_low;

  modport ctl (
    output wr_coc, wr_hdr, wr_ip_hi, wr_ip_lo, wdata,
    input clkout_enable, clkout_root_select, clkout_edge_rate, clkout_divisor,
    input header_word, src_ip_high, src_ip_low
  );
  modport store (
    input wr_coc, wr_hdr, wr_ip_hi, wr_ip_lo, wdata,
    output clkout_enable, clkout_root_select, clkout_edge_rate, clkout_divisor,
    output header_word, src_ip_high, src_ip_low
  );
  modport div (
    input clkout_enable, clkout_root_select, clkout_divisor
  );
endinterface : ptp_cfg_if

/* rtl/ptp_cfg_store.sv */
// Storage of the clock-output control and status-frame configuration registers
`timescale 1ns/1ps
module ptp_cfg_store (
  input wire logic clk_sys,
  input wire logic rstn,
  ptp_cfg_if.store cfg
);
  import ptp_cfg_pkg::*;

  logic clkout_enable_ff;
  logic clkout_root_select_ff;
  logic clkout_edge_rate_ff;
  logic [7:0] clkout_divisor_ff;
  logic [15:0] header_word_ff;
  logic [15:0] src_ip_high_ff;
  logic [15:0] src_ip_low_ff;

  // ----------------------------------------------------------------
  // Clock-output control; bits 12:8 are never stored
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clkout_enable_ff <= CLKOUT_ENABLE_RST;
      clkout_root_select_ff <= CLKOUT_ROOT_SELECT_RST;
      clkout_edge_rate_ff <= CLKOUT_EDGE_RATE_RST;
      clkout_divisor_ff <= CLKOUT_DIVISOR_RST;
    end else if (cfg.wr_coc) begin
      clkout_enable_ff <= cfg.wdata[CLKOUT_ENABLE_BIT];
      clkout_root_select_ff <= cfg.wdata[CLKOUT_ROOT_SELECT_BIT];
      clkout_edge_rate_ff <= cfg.wdata[CLKOUT_EDGE_RATE_BIT];
      clkout_divisor_ff <= cfg.wdata[CLKOUT_DIVISOR_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Status-frame header word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      header_word_ff <= HEADER_CFG_RST;
    end else if (cfg.wr_hdr) begin
      header_word_ff <= cfg.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Source address halves
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_ip_high_ff <= SRC_IP_RST;
    end else if (cfg.wr_ip_hi) begin
      src_ip_high_ff <= cfg.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_ip_low_ff <= SRC_IP_RST;
    end else if (cfg.wr_ip_lo) begin
      src_ip_low_ff <= cfg.wdata;
    end
  end

  assign cfg.clkout_enable = clkout_enable_ff;
  assign cfg.clkout_root_select = clkout_root_select_ff;
  assign cfg.clkout_edge_rate = clkout_edge_rate_ff;
  assign cfg.clkout_divisor = clkout_divisor_ff;
  assign cfg.header_word = header_word_ff;
  assign cfg.src_ip_high = src_ip_high_ff;
  assign cfg.src_ip_low = src_ip_low_ff;

endmodule : ptp_cfg_store

/* rtl/clkout_divider.sv */
// Divide-by-N clock output generator driven by root clock tick enables
`timescale 1ns/1ps
module clkout_divider (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic root_tick_pgm,
  input wire logic root_tick_fco,
  ptp_cfg_if.div cfg,
  output logic clkout
);
  import ptp_cfg_pkg::*;

  logic [7:0] cnt_ff;
  logic [7:0] act_div_ff;
  logic act_sel_ff;
  logic out_ff;
  logic running;
  logic tick;
  logic wrap;
  logic [7:0] nxt_cnt;
  logic [7:0] nxt_div;

  assign running = cfg.clkout_enable && (cfg.clkout_divisor >= CLKOUT_DIVISOR_MIN);
  assign tick = (act_sel_ff == ROOT_PHASE_GENERATION_MODULE) ? root_tick_pgm : root_tick_fco;
  assign wrap = (cnt_ff == act_div_ff - 8'h01);
  assign nxt_cnt = wrap ? 8'h00 : cnt_ff + 8'h01;
  assign nxt_div = wrap ? cfg.clkout_divisor : act_div_ff;

  // ----------------------------------------------------------------
  // Period counter; a running clock takes a new divisor or root select only at a period boundary, a stop at once
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= CLKOUT_DIVISOR_RST - 8'h01;
      act_div_ff <= CLKOUT_DIVISOR_RST;
      act_sel_ff <= CLKOUT_ROOT_SELECT_RST;
      out_ff <= 1'b0;
    end else if (!running) begin
      // Parked at end of period so the restart begins a full high phase
      cnt_ff <= cfg.clkout_divisor - 8'h01;
      act_div_ff <= cfg.clkout_divisor;
      act_sel_ff <= cfg.clkout_root_select;
      out_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff <= nxt_cnt;
      act_div_ff <= nxt_div;
      if (wrap) begin
        act_sel_ff <= cfg.clkout_root_select;
      end
      out_ff <= (nxt_cnt < high_phase_len(nxt_div));
    end
  end

  assign clkout = out_ff;

endmodule : clkout_divider

/* rtl/ptp_clkout_and_status_frame_cfg.sv */
// Page-six register bank: clock-output control and status-frame field source
`timescale 1ns/1ps

module ptp_clkout_and_status_frame_cfg (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic root_tick_pgm,
  input wire logic root_tick_fco,
  output logic clkout,
  output logic clkout_edge_rate,
  input wire logic frame_start,
  input wire logic frame_ipv4,
  input wire logic frame_ready,
  output logic [7:0] frame_data,
  output logic frame_valid,
  output logic frame_last,
  output logic frame_busy,
  output logic [2:0] register_page_select
);
  import ptp_cfg_pkg::*;

  ptp_cfg_if cfg ();

  logic [2:0] page_ff;
  logic page_hit;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic [15:0] nxt_rdata;
  logic edge_rate_ff;

  frame_state_e state_ff;
  frame_state_e nxt_state;
  logic [1:0] idx_ff;
  logic [15:0] snap_hdr_ff;
  logic [15:0] snap_ip_hi_ff;
  logic [15:0] snap_ip_lo_ff;
  logic snap_ipv4_ff;
  logic [7:0] frame_byte;
  logic frame_end;
  logic take;

  // ----------------------------------------------------------------
  // Page selection and write decode
  // ----------------------------------------------------------------
  assign page_hit = (page_ff == CFG_PAGE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      page_ff <= PAGE_SELECT_RST;
    end else if (mgmt_wr && mgmt_addr == ADDR_PAGE_SELECT) begin
      page_ff <= mgmt_wdata[2:0];
    end
  end

  assign cfg.wdata = mgmt_wdata;
  assign cfg.wr_coc = mgmt_wr && page_hit && mgmt_addr == ADDR_CLOCK_OUTPUT_CONTROL;
  assign cfg.wr_hdr = mgmt_wr && page_hit && mgmt_addr == ADDR_STATUS_FRAME_HEADER_CFG;
  assign cfg.wr_ip_hi = mgmt_wr && page_hit && mgmt_addr == ADDR_STATUS_FRAME_SRC_IP_HIGH;
  assign cfg.wr_ip_lo = mgmt_wr && page_hit && mgmt_addr == ADDR_STATUS_FRAME_SRC_IP_LOW;

  // ----------------------------------------------------------------
  // Read mux; page select reads back on any page, other unmapped or off-page reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (mgmt_addr == ADDR_PAGE_SELECT) begin
      nxt_rdata = {13'h0000, page_ff};
    end else if (page_hit) begin
      unique case (mgmt_addr)
        ADDR_CLOCK_OUTPUT_CONTROL: begin
          nxt_rdata = {cfg.clkout_enable, cfg.clkout_root_select, cfg.clkout_edge_rate,
                       CLKOUT_RESERVED_VALUE, cfg.clkout_divisor};
        end
        ADDR_STATUS_FRAME_HEADER_CFG: begin
          nxt_rdata = cfg.header_word;
        end
        ADDR_STATUS_FRAME_SRC_IP_HIGH: begin
          nxt_rdata = cfg.src_ip_high;
        end
        ADDR_STATUS_FRAME_SRC_IP_LOW: begin
          nxt_rdata = cfg.src_ip_low;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 16'h0000;
    end else if (mgmt_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= mgmt_rd;
    end
  end

  // ----------------------------------------------------------------
  // Register store and clock divider
  // ----------------------------------------------------------------
  ptp_cfg_store u_store (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cfg(cfg.store)
  );

  clkout_divider u_divider (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .root_tick_pgm(root_tick_pgm),
    .root_tick_fco(root_tick_fco),
    .cfg(cfg.div),
    .clkout(clkout)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      edge_rate_ff <= CLKOUT_EDGE_RATE_RST;
    end else begin
      edge_rate_ff <= cfg.clkout_edge_rate;
    end
  end

  // ----------------------------------------------------------------
  // Status-frame field sequencer
  // ----------------------------------------------------------------
  assign take = frame_valid && frame_ready;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FRM_IDLE: begin
        if (frame_start) begin
          nxt_state = FRM_HDR;
        end
      end
      FRM_HDR: begin
        if (take && idx_ff == HEADER_BYTES - 2'h1) begin
          nxt_state = snap_ipv4_ff ? FRM_IP : FRM_IDLE;
        end
      end
      FRM_IP: begin
        if (take && idx_ff == SRC_IP_BYTES_M1) begin
          nxt_state = FRM_IDLE;
        end
      end
      default: begin
        nxt_state = FRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= FRM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Fields frozen at frame start so a register write cannot tear a frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      snap_hdr_ff <= HEADER_CFG_RST;
      snap_ip_hi_ff <= SRC_IP_RST;
      snap_ip_lo_ff <= SRC_IP_RST;
      snap_ipv4_ff <= 1'b0;
    end else if (state_ff == FRM_IDLE && frame_start) begin
      snap_hdr_ff <= cfg.header_word;
      snap_ip_hi_ff <= cfg.src_ip_high;
      snap_ip_lo_ff <= cfg.src_ip_low;
      snap_ipv4_ff <= frame_ipv4;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= 2'h0;
    end else if (state_ff == FRM_IDLE || (take && nxt_state != state_ff)) begin
      idx_ff <= 2'h0;
    end else if (take) begin
      idx_ff <= idx_ff + 2'h1;
    end
  end

  // Header octet 0: transport nibble over message kind; octet 1: reserved nibble over version
  always_comb begin
    frame_byte = 8'h00;
    frame_end = 1'b0;
    unique case (state_ff)
      FRM_HDR: begin
        frame_byte = idx_ff[0] ? {snap_hdr_ff[HEADER_RESERVED_NIBBLE_LSB +: 4],
                                  snap_hdr_ff[HEADER_VERSION_LSB +: 4]}
                               : {snap_hdr_ff[HEADER_TRANSPORT_LSB +: 4],
                                  snap_hdr_ff[HEADER_MSG_KIND_LSB +: 4]};
        frame_end = idx_ff[0] && !snap_ipv4_ff;
      end
      FRM_IP: begin
        // Byte order: first, second from high half; third, fourth from low half
        frame_byte = idx_ff[1] ? pick_byte(snap_ip_lo_ff, idx_ff[0])
                               : pick_byte(snap_ip_hi_ff, idx_ff[0]);
        frame_end = (idx_ff == SRC_IP_BYTES_M1);
      end
      default: begin
        frame_byte = 8'h00;
        frame_end = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mgmt_rdata = rdata_ff;
  assign mgmt_rvalid = rvalid_ff;
  assign clkout_edge_rate = edge_rate_ff;
  assign frame_data = frame_byte;
  assign frame_valid = (state_ff != FRM_IDLE);
  assign frame_last = frame_end;
  assign frame_busy = (state_ff != FRM_IDLE);
  assign register_page_select = page_ff;

endmodule : ptp_clkout_and_status_frame_cfg

/* test/ptp_cfg_asserts.sv */
// Concurrent checks on the ports of the page-six configuration bank
`timescale 1ns/1ps
module ptp_cfg_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire logic root_tick_pgm,
  input wire logic root_tick_fco,
  input wire logic clkout,
  input wire logic clkout_edge_rate,
  input wire logic frame_start,
  input wire logic frame_ipv4,
  input wire logic frame_ready,
  input wire logic [7:0] frame_data,
  input wire logic frame_valid,
  input wire logic frame_last,
  input wire logic frame_busy,
  input wire logic [2:0] register_page_select
);
  import ptp_cfg_pkg::*;
  logic [15:0] coc_ff;
  logic [4:0] steady_ff;
  logic [2:0] beat_ff;
  logic ip4_ff;
  logic on_page;
  logic stop_m;
  logic rate_m;
  logic [2:0] wpage;
  assign on_page = register_page_select == CFG_PAGE;
  assign stop_m = !coc_ff[CLKOUT_ENABLE_BIT] || coc_ff[7:0] < CLKOUT_DIVISOR_MIN;
  assign rate_m = coc_ff[CLKOUT_EDGE_RATE_BIT];
  assign wpage = mgmt_wdata[2:0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      coc_ff <= 16'h800a;
    end else if (mgmt_wr && on_page && mgmt_addr == ADDR_CLOCK_OUTPUT_CONTROL) begin
      coc_ff <= mgmt_wdata;
    end
  end
  // Consecutive ticks with divide-by-two from the phase generator
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      steady_ff <= 5'h00;
    end else if (coc_ff[15:14] == 2'h3 && coc_ff[7:0] == 8'h02 && root_tick_pgm) begin
      steady_ff <= steady_ff + {4'h0, steady_ff != 5'h1f};
    end else begin
      steady_ff <= 5'h00;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beat_ff <= 3'h0;
      ip4_ff <= 1'b0;
    end else if (frame_start && !frame_busy) begin
      beat_ff <= 3'h0;
      ip4_ff <= frame_ipv4;
    end else if (frame_valid && frame_ready) begin
      beat_ff <= beat_ff + 3'h1;
    end
  end
  sequence s_open;
    frame_start && !frame_busy;
  endsequence
  sequence s_accept;
    frame_valid && frame_ready;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  page_write_a: assert property (mgmt_wr && mgmt_addr == ADDR_PAGE_SELECT |=>
    register_page_select == $past(wpage)) else $error("page select not stored");
  offpage_zero_a: assert property (mgmt_rd && !on_page && mgmt_addr >= ADDR_CLOCK_OUTPUT_CONTROL &&
    mgmt_addr <= ADDR_STATUS_FRAME_SRC_IP_LOW |=> mgmt_rvalid && mgmt_rdata == 16'h0000) else $error("bank seen off page");
  rsvd_zero_a: assert property (mgmt_rd && mgmt_addr == ADDR_CLOCK_OUTPUT_CONTROL |=>
    mgmt_rdata[12:8] == CLKOUT_RESERVED_VALUE) else $error("reserved bits not zero");
  edge_rate_a: assert property (clkout_edge_rate == $past(rate_m)) else $error("edge rate mismatch");
  stop_low_a: assert property (stop_m |=> !clkout) else $error("stopped clock toggles");
  idle_hold_a: assert property (!root_tick_pgm && !root_tick_fco && !stop_m |=>
    $stable(clkout)) else $error("clock moved without tick");
  fast_div_a: assert property (steady_ff >= 5'h1e |-> clkout != $past(clkout)) else $error("divide by two wrong");
  frame_open_a: assert property (s_open |=> frame_valid) else $error("frame did not open");
  byte_hold_a: assert property (frame_valid && !frame_ready |=>
    frame_valid && $stable(frame_data) && $stable(frame_last)) else $error("byte not held");
  frame_len_a: assert property (s_accept ##0 frame_last |->
    beat_ff == (ip4_ff ? 3'h5 : 3'h1)) else $error("frame length wrong");
endmodule : ptp_cfg_asserts

bind ptp_clkout_and_status_frame_cfg ptp_cfg_asserts chk (.clk_sys(clk_sys), .rstn(rstn),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .root_tick_pgm(root_tick_pgm),
  .root_tick_fco(root_tick_fco), .clkout(clkout), .clkout_edge_rate(clkout_edge_rate),
  .frame_start(frame_start), .frame_ipv4(frame_ipv4), .frame_ready(frame_ready), .frame_data(frame_data),
  .frame_valid(frame_valid), .frame_last(frame_last), .frame_busy(frame_busy),
  .register_page_select(register_page_select));

/* test/status_frame_sink.sv */
// Receiver model that takes status-frame bytes, steady or stalling
`timescale 1ns/1ps
module status_frame_sink (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic frame_valid,
  input wire logic [7:0] frame_data,
  input wire logic frame_last,
  input wire logic stall,
  output logic frame_ready,
  output logic [47:0] got_bytes,
  output logic [2:0] got_n
);
  logic ended_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frame_ready <= 1'b0;
      got_bytes <= 48'h0;
      got_n <= 3'h0;
      ended_ff <= 1'b1;
    end else begin
      frame_ready <= stall ? !frame_ready : 1'b1;
      if (frame_valid && frame_ready) begin
        got_bytes <= ended_ff ? {40'h0, frame_data} : {got_bytes[39:0], frame_data};
        got_n <= ended_ff ? 3'h1 : got_n + 3'h1;
        ended_ff <= frame_last;
      end
    end
  end
endmodule : status_frame_sink

/* test/tb_top.sv */
// Self-checking bench for the page-six configuration bank
`timescale 1ns/1ps
module tb_top;
  import ptp_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic root_tick_pgm = 1'b0;
  logic root_tick_fco = 1'b0;
  logic frame_start = 1'b0;
  logic frame_ipv4 = 1'b0;
  logic stall = 1'b0;
  logic pgm_on = 1'b0;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid, clkout, clkout_edge_rate, frame_ready, frame_valid, frame_last, frame_busy;
  logic [7:0] frame_data;
  logic [2:0] register_page_select;
  logic [47:0] got_bytes;
  logic [2:0] got_n;
  logic [7:0] divs [4] = '{8'h02, 8'h03, 8'hff, 8'h0a};
  logic [15:0] stops [3] = '{16'hc000, 16'hc001, 16'h400a};
  logic [15:0] cfg_val [3] = '{16'ha5c3, 16'h1122, 16'h3344};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  ptp_clkout_and_status_frame_cfg dut (.clk_sys(clk_sys), .rstn(rstn), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .root_tick_pgm(root_tick_pgm), .root_tick_fco(root_tick_fco),
    .clkout(clkout), .clkout_edge_rate(clkout_edge_rate), .frame_start(frame_start),
    .frame_ipv4(frame_ipv4), .frame_ready(frame_ready), .frame_data(frame_data), .frame_valid(frame_valid),
    .frame_last(frame_last), .frame_busy(frame_busy), .register_page_select(register_page_select));
  status_frame_sink mac (.clk_sys(clk_sys), .rstn(rstn), .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_last(frame_last), .stall(stall), .frame_ready(frame_ready), .got_bytes(got_bytes), .got_n(got_n));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Root ticks: phase generator on demand, oscillator every other cycle
  always @(posedge clk_sys) begin
    root_tick_pgm <= #1 pgm_on;
    root_tick_fco <= #1 !root_tick_fco;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    step(1);
    mgmt_wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    step(1);
    mgmt_rd = 1'b0;
    chk(mgmt_rvalid, 1'b1);
    chk(mgmt_rdata, exp);
    step(1);
  endtask : rdchk
  task automatic wait_lvl(input logic v);
    int k;
    k = 0;
    while (clkout !== v && k < 600) begin
      k++;
      step(1);
    end
  endtask : wait_lvl
  task automatic period(input logic [15:0] w, input int eh, input int el);
    wr(ADDR_CLOCK_OUTPUT_CONTROL, w);
    rdchk(ADDR_CLOCK_OUTPUT_CONTROL, w);
    step(40);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    measure(eh, el);
  endtask : period
  // Counts the rest of the current high phase and the low phase after it
  task automatic measure(input int eh, input int el);
    int hi_n;
    int lo_n;
    hi_n = 0;
    lo_n = 0;
    while (clkout === 1'b1 && hi_n < 600) begin
      hi_n++;
      step(1);
    end
    while (clkout === 1'b0 && lo_n < 600) begin
      lo_n++;
      step(1);
    end
    chk(hi_n, eh);
    chk(lo_n, el);
  endtask : measure
  task automatic frame(input logic ip4, input logic slow, input logic [47:0] exp, input logic [2:0] n);
    int k;
    stall = slow;
    frame_ipv4 = ip4;
    frame_start = 1'b1;
    step(2);
    frame_start = 1'b0;
    k = 0;
    while (frame_busy === 1'b1 && k < 100) begin
      k++;
      step(1);
    end
    chk(got_n, n);
    chk(got_bytes, exp);
  endtask : frame
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    step(1);
    wr(ADDR_PAGE_SELECT, 16'h0006);
    chk(register_page_select, CFG_PAGE);
    rdchk(ADDR_CLOCK_OUTPUT_CONTROL, 16'h800a);
    for (int i = 0; i < 3; i++) begin
      rdchk(ADDR_STATUS_FRAME_HEADER_CFG + 5'(i), 16'h0000);
    end
    $display("test reset_values done");
    wr(ADDR_PAGE_SELECT, 16'h0005);
    rdchk(ADDR_CLOCK_OUTPUT_CONTROL, 16'h0000);
    wr(ADDR_STATUS_FRAME_SRC_IP_HIGH, 16'hffff);
    wr(ADDR_PAGE_SELECT, 16'h0006);
    rdchk(ADDR_STATUS_FRAME_SRC_IP_HIGH, 16'h0000);
    rdchk(5'h18, 16'h0000);
    wr(ADDR_CLOCK_OUTPUT_CONTROL, 16'h3fff);
    rdchk(ADDR_CLOCK_OUTPUT_CONTROL, 16'h20ff);
    chk(clkout_edge_rate, 1'b1);
    $display("test paging done");
    pgm_on = 1'b1;
    for (int i = 0; i < 4; i++) begin
      period({8'hc0, divs[i]}, (int'(divs[i]) + 1) / 2, int'(divs[i]) / 2);
    end
    // Divisor change inside a high phase: old period of ten must finish
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wr(ADDR_CLOCK_OUTPUT_CONTROL, 16'hc002);
    measure(3, 5);
    period(16'h8004, 4, 4);
    $display("test divider done");
    for (int i = 0; i < 3; i++) begin
      int hits;
      wr(ADDR_CLOCK_OUTPUT_CONTROL, stops[i]);
      step(2);
      hits = 0;
      repeat (20) begin
        if (clkout !== 1'b0) hits++;
        step(1);
      end
      chk(hits, 0);
    end
    pgm_on = 1'b0;
    wr(ADDR_CLOCK_OUTPUT_CONTROL, 16'h800a);
    $display("test stop done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_STATUS_FRAME_HEADER_CFG + 5'(i), cfg_val[i]);
      rdchk(ADDR_STATUS_FRAME_HEADER_CFG + 5'(i), cfg_val[i]);
    end
    // Header bytes: transport|kind, then reserved|version
    frame(1'b0, 1'b0, 48'h0000_0000_c3a5, 3'h2);
    frame(1'b1, 1'b1, 48'hc3a5_2211_4433, 3'h6);
    $display("test frames done");
    end_sim();
  end
endmodule : tb_top
